//--- rtl/phybcr_pkg.sv
// Constants, register map and field layout for the basic PHY control register
package phybcr_pkg;
  localparam int unsigned ADDR_W     = 5;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned REG_COUNT  = 32;
  localparam int unsigned STD_COUNT  = 16;

  localparam logic [ADDR_W-1:0] BASIC_PHY_CONTROL_IDX = 5'h00;

  localparam int unsigned BIT_SOFT_RESET   = 15;
  localparam int unsigned BIT_LOOP         = 14;
  localparam int unsigned BIT_SPEED_LO     = 13;
  localparam int unsigned BIT_AN_ENABLE    = 12;
  localparam int unsigned BIT_POWER_DOWN   = 11;
  localparam int unsigned BIT_ISOLATE      = 10;
  localparam int unsigned BIT_AN_RESTART   = 9;
  localparam int unsigned BIT_DUPLEX       = 8;
  localparam int unsigned BIT_COL_TEST     = 7;
  localparam int unsigned BIT_SPEED_HI     = 6;

  // Writable storage bits; reserved 5:0 and self-clearing bits excluded
  localparam logic [DATA_W-1:0] STORE_MASK  = 16'h7dc0;
  localparam logic [DATA_W-1:0] CTRL_RESET  = 16'h1140;
  localparam logic [DATA_W-1:0] ZERO_WORD   = 16'h0000;

  localparam logic [1:0] SPEED_10M   = 2'h0;
  localparam logic [1:0] SPEED_100M  = 2'h1;
  localparam logic [1:0] SPEED_1000M = 2'h2;
  localparam logic [1:0] SPEED_RSVD  = 2'h3;
endpackage

//--- rtl/phybcr_top.sv
// Basic PHY control register with management access and control outputs
`timescale 1ns/100ps
`default_nettype none
module phybcr_top (
  input  wire logic                          sys_clk,
  input  wire logic                          reset_n,
  input  wire logic                          mgmt_wr_en,
  input  wire logic                          mgmt_rd_en,
  input  wire logic [phybcr_pkg::ADDR_W-1:0] mgmt_reg_addr,
  input  wire logic [phybcr_pkg::DATA_W-1:0] mgmt_wr_data,
  input  wire logic                          tx_active,
  output logic      [phybcr_pkg::DATA_W-1:0] mgmt_rd_data,
  output logic                               mgmt_std_space,
  output logic                               soft_reset_pulse,
  output logic                               negotiation_restart,
  output logic                               near_end_loop_enable,
  output logic                               an_enable,
  output logic                               power_down,
  output logic                               mac_side_isolate,
  output logic                               collision_test_enable,
  output logic      [1:0]                    forced_speed,
  output logic                               forced_full_duplex,
  output logic                               forced_mode_active,
  output logic                               forced_speed_reserved,
  output logic                               collision_out
);
  import phybcr_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] ctrl;
    logic [DATA_W-1:0] rd_data;
    logic              std_space;
    logic              soft_rst;
    logic              an_restart;
    logic [1:0]        speed_eff;
    logic              duplex_eff;
    logic              forced;
    logic              speed_rsvd;
    logic              collision;
  } phybcr_state_t;

  phybcr_state_t state_reg;
  phybcr_state_t state_next;

  // Power-on image of every flop; soft reset reloads the control word and drops any restart written during its pulse
  localparam phybcr_state_t STATE_RESET = '{
    ctrl:       CTRL_RESET,
    rd_data:    ZERO_WORD,
    std_space:  1'b0,
    soft_rst:   1'b0,
    an_restart: 1'b0,
    speed_eff:  SPEED_10M,
    duplex_eff: 1'b0,
    forced:     1'b0,
    speed_rsvd: 1'b0,
    collision:  1'b0
  };

  // Index decode for the single register held here
  function automatic logic is_ctrl_index(input logic [ADDR_W-1:0] a);
    return (a == BASIC_PHY_CONTROL_IDX);
  endfunction

  // Upper half of the space belongs to vendor blocks elsewhere
  function automatic logic is_std_index(input logic [ADDR_W-1:0] a);
    return (a < ADDR_W'(STD_COUNT));
  endfunction

  function automatic logic [1:0] speed_of(input logic [DATA_W-1:0] c);
    return {c[BIT_SPEED_HI], c[BIT_SPEED_LO]};
  endfunction

  function automatic logic an_on(input logic [DATA_W-1:0] c);
    return c[BIT_AN_ENABLE];
  endfunction

  function automatic logic forced_of(input logic [DATA_W-1:0] c);
    return !an_on(c);
  endfunction

  // Only plain R/W bits are kept; self-clearing and reserved bits never stored
  function automatic logic [DATA_W-1:0] store_of(input logic [DATA_W-1:0] d);
    return d & STORE_MASK;
  endfunction

  // Self-clearing commands: a written one becomes a single-cycle pulse
  function automatic logic pulse_of(
    input logic              wr,
    input logic [DATA_W-1:0] d,
    input int unsigned       b
  );
    return wr && d[b];
  endfunction

  // Self-clearing bits show one while their pulse is still live
  function automatic logic [DATA_W-1:0] read_of(
    input logic [DATA_W-1:0] c,
    input logic              srst,
    input logic              anr
  );
    logic [DATA_W-1:0] w;
    w                 = store_of(c);
    w[BIT_SOFT_RESET] = srst;
    w[BIT_AN_RESTART] = anr;
    return w;
  endfunction

  // Reads of other indices return zero; they live in blocks outside this one
  function automatic logic [DATA_W-1:0] rd_word_of(
    input logic              sel,
    input logic [DATA_W-1:0] c,
    input logic              srst,
    input logic              anr
  );
    logic [DATA_W-1:0] r;
    if (sel) begin
      r = read_of(c, srst, anr);
    end else begin
      r = ZERO_WORD;
    end
    return r;
  endfunction

  function automatic logic [1:0] eff_speed_of(input logic [DATA_W-1:0] c);
    logic [1:0] s;
    if (an_on(c)) begin
      s = SPEED_10M;
    end else begin
      s = speed_of(c);
    end
    return s;
  endfunction

  function automatic logic eff_duplex_of(input logic [DATA_W-1:0] c);
    logic dx;
    if (an_on(c)) begin
      dx = 1'b0;
    end else begin
      dx = c[BIT_DUPLEX];
    end
    return dx;
  endfunction

  // Reserved pattern is passed through and flagged rather than remapped
  function automatic logic rsvd_speed_of(input logic [DATA_W-1:0] c);
    return forced_of(c) && (speed_of(c) == SPEED_RSVD);
  endfunction

  // Collision test is not gated by loopback; software keeps that pairing
  function automatic logic collision_of(
    input logic [DATA_W-1:0] c,
    input logic              tx
  );
    return c[BIT_COL_TEST] && tx;
  endfunction

  // Soft reset wins over any write landing in the same cycle
  function automatic logic [DATA_W-1:0] ctrl_next_of(
    input logic [DATA_W-1:0] c,
    input logic              srst,
    input logic              wr,
    input logic [DATA_W-1:0] d
  );
    logic [DATA_W-1:0] n;
    if (srst) begin
      n = CTRL_RESET;
    end else if (wr) begin
      n = store_of(d);
    end else begin
      n = c;
    end
    return n;
  endfunction

  // Decoded strobes for this cycle
  logic sel_ctrl;
  logic wr_ctrl;
  logic wr_srst;
  logic wr_anr;

  always_comb begin
    state_next = state_reg;
    sel_ctrl   = is_ctrl_index(mgmt_reg_addr);
    wr_ctrl    = mgmt_wr_en && sel_ctrl;
    wr_srst    = pulse_of(wr_ctrl, mgmt_wr_data, BIT_SOFT_RESET);
    wr_anr     = pulse_of(wr_ctrl, mgmt_wr_data, BIT_AN_RESTART);

    // Pulses stand for exactly one cycle after the accepting edge
    state_next.soft_rst   = wr_srst;
    state_next.an_restart = wr_anr && !state_reg.soft_rst;
    state_next.ctrl       = ctrl_next_of(state_reg.ctrl, state_reg.soft_rst, wr_ctrl,
                                         mgmt_wr_data);

    if (mgmt_rd_en) begin
      state_next.std_space = is_std_index(mgmt_reg_addr);
      state_next.rd_data   = rd_word_of(sel_ctrl, state_reg.ctrl, state_reg.soft_rst,
                                        state_reg.an_restart);
    end

    state_next.forced     = forced_of(state_next.ctrl);
    state_next.speed_eff  = eff_speed_of(state_next.ctrl);
    state_next.duplex_eff = eff_duplex_of(state_next.ctrl);
    state_next.speed_rsvd = rsvd_speed_of(state_next.ctrl);
    state_next.collision  = collision_of(state_reg.ctrl, tx_active);
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign mgmt_rd_data          = state_reg.rd_data;
  assign mgmt_std_space        = state_reg.std_space;
  assign soft_reset_pulse      = state_reg.soft_rst;
  assign negotiation_restart   = state_reg.an_restart;
  assign near_end_loop_enable  = state_reg.ctrl[BIT_LOOP];
  assign an_enable             = state_reg.ctrl[BIT_AN_ENABLE];
  assign power_down            = state_reg.ctrl[BIT_POWER_DOWN];
  assign mac_side_isolate      = state_reg.ctrl[BIT_ISOLATE];
  assign collision_test_enable = state_reg.ctrl[BIT_COL_TEST];
  assign forced_speed          = state_reg.speed_eff;
  assign forced_full_duplex    = state_reg.duplex_eff;
  assign forced_mode_active    = state_reg.forced;
  assign forced_speed_reserved = state_reg.speed_rsvd;
  assign collision_out         = state_reg.collision;
endmodule
`default_nettype wire

//--- tb/phybcr_sva.sv
// Port assertions for the basic PHY control register
`timescale 1ns/100ps
`default_nettype none
module phybcr_sva (
  input wire logic        sys_clk, reset_n, mgmt_wr_en, mgmt_rd_en, tx_active, mgmt_std_space,
  input wire logic [4:0]  mgmt_reg_addr,
  input wire logic [15:0] mgmt_wr_data, mgmt_rd_data,
  input wire logic        soft_reset_pulse, negotiation_restart, near_end_loop_enable,
  input wire logic        forced_full_duplex, collision_test_enable, collision_out,
  input wire logic [1:0]  forced_speed
);
  // Plain write to index 0; writes in the soft-reset cycle are discarded
  wire logic w0 = mgmt_wr_en && mgmt_reg_addr == 5'h00 && !mgmt_wr_data[15] && !soft_reset_pulse;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  property p_srst; mgmt_wr_en && mgmt_reg_addr == 5'h00 && mgmt_wr_data[15] && !soft_reset_pulse
    |=> soft_reset_pulse ##1 !soft_reset_pulse; endproperty
  a_srst: assert property (p_srst) else $error("soft reset pulse wrong");
  property p_loop; w0 |=> near_end_loop_enable == $past(mgmt_wr_data[14]); endproperty
  a_loop: assert property (p_loop) else $error("loopback level wrong");
  property p_spd; w0 && !mgmt_wr_data[12]
    |=> forced_speed == {$past(mgmt_wr_data[6]), $past(mgmt_wr_data[13])}; endproperty
  a_spd: assert property (p_spd) else $error("forced speed wrong");
  property p_an; w0 && mgmt_wr_data[12] |=> forced_speed == 2'h0 && !forced_full_duplex; endproperty
  a_an: assert property (p_an) else $error("forced bits not ignored");
  property p_rsta; w0 && mgmt_wr_data[9] |=> negotiation_restart; endproperty
  a_rsta: assert property (p_rsta) else $error("restart pulse missing");
  property p_col; collision_test_enable && tx_active |=> collision_out; endproperty
  a_col: assert property (p_col) else $error("collision not shown");
  property p_rsv; mgmt_rd_en |=> mgmt_rd_data[5:0] == 6'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
  property p_std; mgmt_rd_en |=> mgmt_std_space == ($past(mgmt_reg_addr) < 5'h10); endproperty
  a_std: assert property (p_std) else $error("space flag wrong");
  c_srst: cover property (soft_reset_pulse);
  c_rsta: cover property (negotiation_restart);
  c_col: cover property (collision_out);
endmodule
bind phybcr_top phybcr_sva u_phybcr_sva (.*);
`default_nettype wire

//--- tb/phybcr_mac_model.sv
// Station management master driving the register port
`timescale 1ns/100ps
`default_nettype none
module phybcr_mac_model (
  input  wire logic        sys_clk,
  input  wire logic [15:0] mgmt_rd_data,
  output logic             mgmt_wr_en, mgmt_rd_en,
  output logic [4:0]       mgmt_reg_addr,
  output logic [15:0]      mgmt_wr_data
);
  initial {mgmt_wr_en, mgmt_rd_en, mgmt_reg_addr, mgmt_wr_data} = 23'h000000;
  task automatic access(input logic w, input logic [4:0] a, input logic [15:0] d,
                        output logic [15:0] q);
    @(posedge sys_clk) #1;
    {mgmt_wr_en, mgmt_rd_en, mgmt_reg_addr, mgmt_wr_data} = {w, !w, a, d};
    @(posedge sys_clk) #1;
    {mgmt_wr_en, mgmt_rd_en} = 2'h0;
    // Released lines flip so stale values never look valid
    {mgmt_reg_addr, mgmt_wr_data} = ~{mgmt_reg_addr, mgmt_wr_data};
    q = mgmt_rd_data;
  endtask
endmodule
`default_nettype wire

//--- tb/phybcr_top_test.sv
// Self-checking bench for the basic PHY control register
`timescale 1ns/100ps
`default_nettype none
module phybcr_top_test;
  import phybcr_pkg::*;
  logic sys_clk = 1'b0, reset_n = 1'b0, tx_active = 1'b0, mgmt_wr_en, mgmt_rd_en;
  logic [4:0] mgmt_reg_addr;
  logic [15:0] mgmt_wr_data, mgmt_rd_data, q, d;
  logic [1:0] forced_speed;
  logic mgmt_std_space, soft_reset_pulse, negotiation_restart, near_end_loop_enable, an_enable;
  logic power_down, mac_side_isolate, collision_test_enable, forced_full_duplex;
  logic forced_mode_active, forced_speed_reserved, collision_out;
  int miscompares = 0, total_checks = 0;
  phybcr_top u_phybcr_top (.*);
  phybcr_mac_model u_phybcr_mac_model (.*);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] v);
    u_phybcr_mac_model.access(w, a, v, q);
  endtask
  // Forced speed, duplex, forced flag and reserved flag
  function automatic logic [4:0] exp_fwd(input logic [15:0] v);
    return v[12] ? 5'h00 : {v[6], v[13], v[8], 1'b1, v[6] & v[13]};
  endfunction
  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial forever #4 sys_clk = ~sys_clk;
  initial begin
    #100000;
    miscompares++;
    print_verdict;
  end
  initial begin
    d = $urandom(32'ha29cbee0);
    repeat (6) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    acc(1'b0, 5'h00, 16'h0000);
    chk(q, CTRL_RESET);
    chk(16'({forced_speed, forced_full_duplex, forced_mode_active, forced_speed_reserved,
             an_enable}), 16'h0001);
    acc(1'b1, 5'h05, 16'h4000);
    acc(1'b0, 5'h00, 16'h0000);
    chk(q, CTRL_RESET);
    for (int i = 1; i < 32; i++) begin
      acc(1'b0, 5'(i), 16'h0000);
      chk(q | 16'(mgmt_std_space), 16'(i < 16));
    end
    for (int i = 0; i < 24; i++) begin
      d = 16'($urandom) & 16'h7fff;
      if (i < 4) {d[13], d[12], d[6]} = {i[0], 1'b0, i[1]};
      tx_active = 1'($urandom);
      acc(1'b1, 5'h00, d);
      chk(16'(negotiation_restart), 16'(d[9]));
      acc(1'b0, 5'h00, 16'h0000);
      chk(q, d & STORE_MASK);
      chk(16'({near_end_loop_enable, power_down, mac_side_isolate, collision_out, an_enable,
               collision_test_enable}),
          16'({d[14], d[11], d[10], d[7] & tx_active, d[12], d[7]}));
      chk(16'({forced_speed, forced_full_duplex, forced_mode_active, forced_speed_reserved}),
          16'(exp_fwd(d)));
    end
    acc(1'b1, 5'h00, 16'h8000);
    chk(16'(soft_reset_pulse), 16'h0001);
    acc(1'b0, 5'h00, 16'h0000);
    chk(q, CTRL_RESET);
    print_verdict;
  end
endmodule
`default_nettype wire
